// file: cimf_pkg.sv
// Purpose: Constants for the per-CPU interrupt mode and flag logic
// Assumes: One CPU clock domain, asynchronous active-low reset
// Notes: Interrupt modes field layout is a local bit assignment
//
// Operation
// - With the monitor-instruction enable set, a 001ijk instruction with j nonzero issued outside monitor mode sets the monitor-instruction flag.
// - In monitor mode the monitor-instruction enable has no effect and such an issue sets no flag.
// - A channel transfer completion sets the I/O flag when system I/O enable is on and this CPU is the lowest qualifying one.
// - An operand range error raises an interrupt only while the operand-range mode bit is set.
// - A programmable clock request raises an interrupt only while its mode bit is set.
// - A program range error flag sets on a fetch violation only while the program-range mode bit is set.
// - A register read parity mismatch raises an interrupt while the register-parity mode bit is set.
// - A real-time clock request raises an interrupt only while its mode bit is set.
// - An uncorrectable memory read error sets its flag while its mode bit is set and enabled.
// - A correctable memory read error sets its flag while its mode bit is set.
// - The maintenance interrupt signal becoming active sets its flag while its mode bit is set and enabled.
// - The maintenance interface takes the external board interrupt and forwards it to the CPU it names.
// - Mode bits are held per program in the saved context and are loaded and saved with it.
// - Every context exchange sets the interrupt-modes enable flag.
// - Monitor mode inhibits every source except memory errors.
// - An I/O interrupt is taken only with I/O mode and modes enable set and no lower CPU qualifying.
package cimf_pkg;
  // =====================================================
  // Interrupt modes field bit positions
  localparam int MODE_W = 10;
  localparam int MB_MONI = 0;
  localparam int MB_IO = 1;
  localparam int MB_OPR = 2;
  localparam int MB_PCLK = 3;
  localparam int MB_PRR = 4;
  localparam int MB_RPAR = 5;
  localparam int MB_RTC = 6;
  localparam int MB_UMEM = 7;
  localparam int MB_CMEM = 8;
  localparam int MB_MAINT = 9;
  // =====================================================
  // Flag vector bit positions
  localparam int FLAG_W = 10;
  localparam int FB_MONI = 0;
  localparam int FB_IO = 1;
  localparam int FB_OPR = 2;
  localparam int FB_PCLK = 3;
  localparam int FB_PRR = 4;
  localparam int FB_RPAR = 5;
  localparam int FB_RTC = 6;
  localparam int FB_UMEM = 7;
  localparam int FB_CMEM = 8;
  localparam int FB_MAINT = 9;
  // =====================================================
  // Reset values and decode constants
  localparam logic [MODE_W-1:0] MODES_RST = 10'h000;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 10'h000;
  localparam logic [6:0] MONI_OPC = 7'h01;
  localparam int NUM_CPU_DEF = 4;
  localparam int CPU_ID_W_DEF = 2;
endpackage

// file: cimf_maint_fwd.sv
// Purpose: Forwards an external board interrupt to the designated CPU
// Assumes: Request and CPU number are valid in the same cycle
// Notes: Output is one registered pulse per incoming request
`timescale 1ns/1ps
`default_nettype none
module cimf_maint_fwd #(
  parameter int NUM_CPU = cimf_pkg::NUM_CPU_DEF,
  parameter int ID_W = cimf_pkg::CPU_ID_W_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_board_irq,
  input wire logic [ID_W-1:0] i_board_cpu,
  output logic [NUM_CPU-1:0] o_cpu_irq
);
  // =====================================================
  // Decode and register
  logic [NUM_CPU-1:0] fwd_r;
  logic [NUM_CPU-1:0] fwd_nxt;

  always_comb begin
    fwd_nxt = '0;
    for (int k = 0; k < NUM_CPU; k++) begin
      if (i_board_irq && (i_board_cpu == ID_W'(k))) begin
        fwd_nxt[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fwd_r <= '0;
    end else begin
      fwd_r <= fwd_nxt;
    end
  end

  assign o_cpu_irq = fwd_r;
endmodule
`default_nettype wire

// file: cimf_irq_logic.sv
// Purpose: Per-CPU interrupt qualification, flags and request
// Assumes: Event inputs are one-cycle pulses synchronous to the clock
// Notes: Flags are cleared by i_flags_clear, not by the exchange load; a new event wins over clear
`timescale 1ns/1ps
`default_nettype none
module cimf_irq_logic
  import cimf_pkg::*;
#(
  parameter int NUM_CPU = NUM_CPU_DEF,
  parameter int ID_W = CPU_ID_W_DEF,
  parameter int CPU_NUM = 0
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_exch_load,
  input wire logic [MODE_W-1:0] i_ctx_modes,
  input wire logic i_ctx_supervisor,
  input wire logic i_flags_clear,
  input wire logic i_instr_issue,
  input wire logic [15:0] i_instr_parcel,
  input wire logic i_system_io_irq_enable,
  input wire logic [NUM_CPU-1:0] i_cpu_io_qual,
  input wire logic i_low_speed_channel_done,
  input wire logic i_very_high_speed_channel_done,
  input wire logic i_operand_range_err,
  input wire logic i_prog_clock_req,
  input wire logic i_program_range_err,
  input wire logic i_reg_parity_err,
  input wire logic i_rt_clock_req,
  input wire logic i_mem_read,
  input wire logic i_mem_uncorr_err,
  input wire logic i_mem_corr_err,
  input wire logic i_maint_ch40_irq,
  input wire logic i_external_irq_board,
  input wire logic [ID_W-1:0] i_external_irq_board_cpu,
  output logic [MODE_W-1:0] o_ctx_modes,
  output logic o_supervisor_mode_bit,
  output logic o_irq_modes_enable_flag,
  output logic o_io_qual,
  output logic [FLAG_W-1:0] o_irq_flags,
  output logic o_io_irq_flag,
  output logic o_uncorr_mem_error_flag,
  output logic o_corr_mem_error_flag,
  output logic o_irq_req,
  output logic [NUM_CPU-1:0] o_maint_irq_interface
);
  // =====================================================
  // Helpers
  function automatic logic is_moni_instr(input logic [15:0] p);
    return (p[15:9] == MONI_OPC) && (p[5:3] != 3'h0);
  endfunction

  function automatic logic lower_qual(input logic [NUM_CPU-1:0] q);
    logic r;
    r = 1'b0;
    for (int k = 0; k < NUM_CPU; k++) begin
      if (k < CPU_NUM) begin
        r = r | q[k];
      end
    end
    return r;
  endfunction

  // =====================================================
  // Maintenance interface
  cimf_maint_fwd #(
    .NUM_CPU(NUM_CPU),
    .ID_W(ID_W)
  ) u_fwd (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_board_irq(i_external_irq_board),
    .i_board_cpu(i_external_irq_board_cpu),
    .o_cpu_irq(o_maint_irq_interface)
  );

  // =====================================================
  // Context state
  logic [MODE_W-1:0] modes_r;
  logic [MODE_W-1:0] modes_nxt;
  logic sup_r;
  logic sup_nxt;
  logic eim_r;
  logic eim_nxt;
  logic qual_r;
  logic qual_nxt;

  always_comb begin
    modes_nxt = modes_r;
    sup_nxt = sup_r;
    eim_nxt = eim_r;
    if (i_exch_load) begin
      modes_nxt = i_ctx_modes;
      sup_nxt = i_ctx_supervisor;
      eim_nxt = 1'b1;
    end
    qual_nxt = modes_nxt[MB_IO] & eim_nxt;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      modes_r <= MODES_RST;
      sup_r <= 1'b0;
      eim_r <= 1'b0;
      qual_r <= 1'b0;
    end else begin
      modes_r <= modes_nxt;
      sup_r <= sup_nxt;
      eim_r <= eim_nxt;
      qual_r <= qual_nxt;
    end
  end

  // =====================================================
  // Flag qualification
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] set_v;
  logic maint_d_r;
  logic maint_d_nxt;
  logic req_r;
  logic req_nxt;
  logic ext_maint;
  logic user_ok;
  logic en_ok;

  always_comb begin
    ext_maint = i_maint_ch40_irq | o_maint_irq_interface[CPU_NUM];
    maint_d_nxt = ext_maint;
    user_ok = ~sup_r;
    en_ok = eim_r;
    set_v = '0;
    set_v[FB_MONI] = modes_r[MB_MONI] & user_ok & i_instr_issue &
                     is_moni_instr(i_instr_parcel);
    set_v[FB_IO] = i_system_io_irq_enable & qual_r & user_ok &
                   ~lower_qual(i_cpu_io_qual) &
                   (i_low_speed_channel_done |
                    i_very_high_speed_channel_done);
    set_v[FB_OPR] = modes_r[MB_OPR] & user_ok &
                    i_operand_range_err;
    set_v[FB_PCLK] = modes_r[MB_PCLK] & en_ok & user_ok &
                     i_prog_clock_req;
    set_v[FB_PRR] = modes_r[MB_PRR] & user_ok &
                    i_program_range_err;
    set_v[FB_RPAR] = modes_r[MB_RPAR] & user_ok &
                     i_reg_parity_err;
    set_v[FB_RTC] = modes_r[MB_RTC] & en_ok & user_ok &
                    i_rt_clock_req;
    set_v[FB_UMEM] = modes_r[MB_UMEM] & en_ok & i_mem_read &
                     i_mem_uncorr_err;
    set_v[FB_CMEM] = modes_r[MB_CMEM] & i_mem_read &
                     i_mem_corr_err;
    set_v[FB_MAINT] = modes_r[MB_MAINT] & en_ok & user_ok &
                      ext_maint & ~maint_d_r;
    flags_nxt = i_flags_clear ? set_v : (flags_r | set_v);
    req_nxt = |flags_nxt;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_r <= FLAGS_RST;
      maint_d_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      maint_d_r <= maint_d_nxt;
      req_r <= req_nxt;
    end
  end

  // =====================================================
  // Outputs
  assign o_ctx_modes = modes_r;
  assign o_supervisor_mode_bit = sup_r;
  assign o_irq_modes_enable_flag = eim_r;
  assign o_io_qual = qual_r;
  assign o_irq_flags = flags_r;
  assign o_io_irq_flag = flags_r[FB_IO];
  assign o_uncorr_mem_error_flag = flags_r[FB_UMEM];
  assign o_corr_mem_error_flag = flags_r[FB_CMEM];
  assign o_irq_req = req_r;
endmodule
`default_nettype wire

// file: cimf_irq_logic_asserts.sv
// Purpose: Port assertions for the interrupt mode and flag logic
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every cimf_irq_logic instance
`timescale 1ns/1ps
`default_nettype none
module cimf_irq_asserts
  import cimf_pkg::*;
#(
  parameter int NUM_CPU = 4,
  parameter int ID_W = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_exch_load,
  input wire logic [MODE_W-1:0] i_ctx_modes,
  input wire logic i_instr_issue,
  input wire logic [15:0] i_instr_parcel,
  input wire logic i_mem_read,
  input wire logic i_mem_corr_err,
  input wire logic i_rt_clock_req,
  input wire logic i_external_irq_board,
  input wire logic [ID_W-1:0] i_external_irq_board_cpu,
  input wire logic [MODE_W-1:0] o_ctx_modes,
  input wire logic o_supervisor_mode_bit,
  input wire logic o_irq_modes_enable_flag,
  input wire logic [FLAG_W-1:0] o_irq_flags,
  input wire logic o_corr_mem_error_flag,
  input wire logic o_irq_req,
  input wire logic [NUM_CPU-1:0] o_maint_irq_interface
);
  // ================================================
  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_moni_issue;
    i_instr_issue && i_instr_parcel[15:9] == MONI_OPC &&
      i_instr_parcel[5:3] != 3'h0;
  endsequence
  sequence s_board_once;
    i_external_irq_board ##1 !i_external_irq_board;
  endsequence
  chk_eim_set: assert property (i_exch_load |=> o_irq_modes_enable_flag)
    else $error("modes enable flag not set by exchange");
  chk_modes_load: assert property (i_exch_load |=>
    o_ctx_modes == $past(i_ctx_modes))
    else $error("context modes not loaded");
  chk_req_level: assert property (o_irq_req == (|o_irq_flags))
    else $error("request does not follow flags");
  chk_moni_set: assert property (s_moni_issue ##0
    (o_ctx_modes[MB_MONI] && !o_supervisor_mode_bit) |=> o_irq_flags[FB_MONI])
    else $error("monitor instruction flag missed");
  chk_moni_block: assert property (o_supervisor_mode_bit &&
    !o_irq_flags[FB_MONI] |=> !o_irq_flags[FB_MONI])
    else $error("monitor instruction flag set in monitor mode");
  chk_corr_mem: assert property (i_mem_read && i_mem_corr_err &&
    o_ctx_modes[MB_CMEM] |=> o_corr_mem_error_flag)
    else $error("correctable memory flag missed");
  chk_rtc_gate: assert property (i_rt_clock_req && !o_ctx_modes[MB_RTC] &&
    !o_irq_flags[FB_RTC] |=> !o_irq_flags[FB_RTC])
    else $error("real-time flag set with mode off");
  chk_fwd_pulse: assert property (s_board_once |->
    o_maint_irq_interface[$past(i_external_irq_board_cpu)] ##1
    !o_maint_irq_interface[$past(i_external_irq_board_cpu, 2)])
    else $error("board request not forwarded as one pulse");
endmodule
bind cimf_irq_logic cimf_irq_asserts #(.NUM_CPU(NUM_CPU), .ID_W(ID_W)) u_chk (.*);
`default_nettype wire

// file: cimf_src_model.sv
// Purpose: Event sources seen by the interrupt logic
// Assumes: Select 4'hf means no event
// Notes: Each event is a single registered pulse
`timescale 1ns/1ps
`default_nettype none
module cimf_src_model (
  input wire logic i_sys_clk,
  input wire logic [3:0] i_sel,
  output logic [10:0] o_ev
);
  logic [10:0] ev_r = 11'h000;
  // Lines return low after one cycle, so edges stay distinct
  always @(posedge i_sys_clk) begin
    ev_r <= (i_sel == 4'hf) ? 11'h000 : 11'h001 << i_sel;
  end
  assign o_ev = ev_r;
endmodule
`default_nettype wire

// file: cimf_irq_logic_tb.sv
// Purpose: Self-checking bench for the interrupt mode and flag logic
// Assumes: CPU number 1, so bit 0 of the qualifier blocks I/O
// Notes: First pass enables all, later passes are random
`timescale 1ns/1ps
`default_nettype none
module cimf_irq_logic_tb;
  import cimf_pkg::*;
  logic i_sys_clk = 0, i_resetn = 0, i_exch_load = 0, i_ctx_supervisor = 0;
  logic i_flags_clear = 0, i_system_io_irq_enable = 0, i_mem_read = 0;
  logic i_instr_issue, i_low_speed_channel_done, i_very_high_speed_channel_done;
  logic i_operand_range_err, i_prog_clock_req, i_program_range_err;
  logic i_reg_parity_err, i_rt_clock_req, i_mem_uncorr_err, i_mem_corr_err;
  logic i_maint_ch40_irq, i_external_irq_board, o_supervisor_mode_bit;
  logic o_irq_modes_enable_flag, o_io_qual, o_io_irq_flag, o_irq_req;
  logic o_uncorr_mem_error_flag, o_corr_mem_error_flag;
  logic [MODE_W-1:0] i_ctx_modes = 0, o_ctx_modes, fl;
  logic [FLAG_W-1:0] o_irq_flags;
  logic [15:0] i_instr_parcel = 0, r, p;
  logic [3:0] i_cpu_io_qual = 0, o_maint_irq_interface, sel = 4'hf, ms = 0;
  logic [1:0] i_external_irq_board_cpu = 0;
  logic [10:0] ev;
  logic [30:0] q[$];
  logic e;
  int n_tests = 0, num_errors = 0, k, b;
  event res_ev;
  cimf_irq_logic #(.CPU_NUM(1)) u_cimf_irq_logic (.*);
  cimf_src_model u_cimf_src_model (.i_sys_clk(i_sys_clk), .i_sel(sel), .o_ev(ev));
  assign {i_external_irq_board, i_maint_ch40_irq, i_mem_corr_err,
    i_mem_uncorr_err, i_rt_clock_req, i_reg_parity_err, i_program_range_err,
    i_prog_clock_req, i_operand_range_err} = ev[10:2];
  assign i_instr_issue = ev[0];
  assign i_low_speed_channel_done = ev[1] & !i_instr_parcel[0];
  assign i_very_high_speed_channel_done = ev[1] & i_instr_parcel[0];
  always #2.5 i_sys_clk = ~i_sys_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [30:0] seen, input logic [30:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL port state exp %h seen %h", exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(res_ev) begin
    chk({o_ctx_modes, o_supervisor_mode_bit, o_irq_modes_enable_flag, o_io_qual,
      o_irq_req, o_irq_flags, o_io_irq_flag, o_uncorr_mem_error_flag,
      o_corr_mem_error_flag, ms}, q.pop_front());
  end
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    r = 16'h000f;
    repeat (12) @(posedge i_sys_clk);
    #1 i_resetn = 1;
    for (int i = 0; i < 110; i++) begin
      r = lfsr(r);
      p = lfsr(r);
      if (i < 11) begin
        r = 16'h6bff;
        p[15] = 1'b1;
      end
      k = i % 11;
      @(posedge i_sys_clk) #1;
      {i_external_irq_board_cpu, i_mem_read} = r[15:13];
      {i_cpu_io_qual, i_system_io_irq_enable} = {p[12:10], r[12:11]};
      {i_ctx_supervisor, i_ctx_modes} = r[10:0];
      i_instr_parcel = {p[15] ? 7'h01 : p[15:9], p[8:0]};
      ms = '0;
      i_exch_load = 1;
      i_flags_clear = 1;
      @(posedge i_sys_clk) #1;
      i_exch_load = 0;
      i_flags_clear = 0;
      sel = 4'(k);
      @(posedge i_sys_clk) #1;
      sel = 4'hf;
      for (int t = 0; t < 4; t++) begin
        @(posedge i_sys_clk) #1;
        ms |= o_maint_irq_interface;
      end
      b = (k == 10) ? FB_MAINT : k;
      e = r[b] & (!r[10] | b == FB_UMEM | b == FB_CMEM);
      case (b)
        FB_MONI: e &= i_instr_parcel[15:9] == MONI_OPC && p[5:3] != 3'h0;
        FB_IO: e &= r[11] & !r[12];
        FB_UMEM, FB_CMEM: e &= r[13];
        default: ;
      endcase
      if (k == 10) e &= r[15:14] == 2'h1;
      fl = '0;
      fl[b] = e;
      q.push_back({r[9:0], r[10], 1'b1, r[MB_IO], e, fl, fl[FB_IO],
        fl[FB_UMEM], fl[FB_CMEM],
        (k == 10) ? (4'h1 << r[15:14]) : 4'h0});
      -> res_ev;
    end
    for (int t = 0; t < 5 && q.size() > 0; t++) @(posedge i_sys_clk);
    if (q.size() != 0) num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
